// *** core/rsil_defs.vh ***
// Purpose: constants for the radio strobe and interrupt logic
// Assumes: 8-bit special function register access from the CPU
// Notes:   offsets are SFR addresses; strobe register offset is arbitrary
`ifndef RSIL_DEFS_VH
`define RSIL_DEFS_VH

`define RSIL_ADDR_EVENT_MASK   8'h91
`define RSIL_ADDR_EVENT_FLAGS  8'he9
`define RSIL_ADDR_STROBE       8'he1

`define RSIL_MASK_RESET        8'h00
`define RSIL_FLAGS_RESET       8'h00

`define RSIL_STB_SYNTH_ON      8'h00
`define RSIL_STB_CALIBRATE     8'h01
`define RSIL_STB_RECEIVE       8'h02
`define RSIL_STB_TRANSMIT      8'h03
`define RSIL_STB_IDLE          8'h04

`define RSIL_BIT_TXUNF         7
`define RSIL_BIT_RXOVF         6
`define RSIL_BIT_TIMEOUT       5
`define RSIL_BIT_DONE          4
`define RSIL_BIT_CS            3
`define RSIL_BIT_PREAMBLE      2
`define RSIL_BIT_CCA           1
`define RSIL_BIT_SYNC          0

`define RSIL_CAL_CYCLES        16'd64

`define RSIL_ST_IDLE           3'd0
`define RSIL_ST_CAL            3'd1
`define RSIL_ST_FS_ON          3'd2
`define RSIL_ST_RX             3'd3
`define RSIL_ST_TX             3'd4
`define RSIL_ST_RX_OVF         3'd5
`define RSIL_ST_TX_UNF         3'd6

`endif

// *** core/rsil_edge_flag.v ***
// Purpose: one sticky event flag set on a rising edge of its condition
// Assumes: condition synchronous to clk_i
// Notes:   set beats a same-cycle software clear
`default_nettype none
module rsil_edge_flag (
	input  wire clk_i,
	input  wire rst_n_i,
	input  wire cond_i,
	input  wire wr_i,
	input  wire wr_bit_i,
	output reg  flag_o
);
	reg cond_q;
	wire rise = cond_i & ~cond_q;

	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cond_q <= 1'b0;
			flag_o <= 1'b0;
		end else begin
			cond_q <= cond_i;
			if (rise)
				flag_o <= 1'b1; // [R10]
			else if (wr_i && !wr_bit_i)
				flag_o <= 1'b0; // [R19]
		end
	end
endmodule // rsil_edge_flag
`default_nettype wire

// *** core/rsil_top.v ***
// Function
// [R1] Strobe 0x00 turns synthesizer on, calibrating first when auto calibration set.
// [R2] Strobe 0x00 in receive with clear channel check goes to synth-only wait.
// [R3] Strobe 0x01 calibrates then switches synthesizer off; allowed from idle.
// [R4] Strobe 0x02 enters receive, calibrating first from idle with auto calibration.
// [R5] Strobe 0x03 in idle enters transmit, calibrating first with auto calibration.
// [R6] Strobe 0x03 in receive with clear channel check transmits only if clear.
// [R7] Strobe 0x04 forces idle with synthesizer off.
// [R8] Strobes are single bytes; undefined values do nothing.
// [R9] Two interrupt requests: data byte request and combined radio request.
// [R10] Event flags set only on rising edge of their condition.
// [R11] Data byte flag: byte waiting in receive, room for byte in transmit.
// [R12] Data byte request only while its enable is 1.
// [R13] Eight events set own flag regardless of mask.
// [R14] Flag set with matching mask bit sets combined radio flag.
// [R15] Combined request raised while combined flag set and its enable is 1.
// [R16] Flag bits 7..0: underflow, overflow, timeout, done, carrier, preamble, clear, sync; reset 0.
// [R17] Packet done also set on underflow or overflow.
// [R18] Mask register: one read-write enable per flag position, reset 0.
// [R19] Writing 0 clears a flag, writing 1 leaves it; flags stay until cleared.
// [R20] Data register holds one byte; unread byte overwritten means receive overflow.
// [R21] Too few transmit bytes means underflow; idle strobe leaves overflow or underflow.
//
// Purpose: command strobe decode, radio state, event flags and CPU interrupt requests
// Assumes: SFR writes and reads are single-cycle strobes synchronous to clk_i
// Notes:   analog synthesizer calibration modelled as a fixed cycle count
`default_nettype none
`include "rsil_defs.vh"
module rsil_top #(
	parameter [15:0] CAL_CYCLES = `RSIL_CAL_CYCLES
) (
	input  wire       clk_i,
	input  wire       resetn_i,
	input  wire       sfr_wr_i,
	input  wire       sfr_rd_i,
	input  wire [7:0] sfr_addr_i,
	input  wire [7:0] sfr_wdata_i,
	output reg  [7:0] sfr_rdata_o,
	input  wire       data_wr_i,
	input  wire [7:0] data_wdata_i,
	input  wire       data_rd_i,
	output reg  [7:0] data_rdata_o,
	input  wire       rx_byte_i,
	input  wire [7:0] rx_data_i,
	input  wire       tx_byte_take_i,
	output reg        tx_byte_valid_o,
	output reg  [7:0] tx_byte_o,
	input  wire       rx_timeout_i,
	input  wire       packet_done_i,
	input  wire       carrier_sense_i,
	input  wire       preamble_quality_i,
	input  wire       clear_channel_i,
	input  wire       sync_detected_i,
	input  wire       auto_calibration_setting_i,
	input  wire       cca_enable_i,
	input  wire       data_byte_irq_enable_i,
	input  wire       radio_irq_enable_i,
	input  wire       data_byte_flag_clr_i,
	input  wire       radio_cpu_flag_clr_i,
	output reg        data_byte_cpu_flag_o,
	output reg        combined_radio_cpu_flag_o,
	output reg        data_byte_irq_o,
	output reg        radio_irq_o,
	output reg  [2:0] radio_state_o,
	output reg        synth_on_o
);
	reg        rst_meta;
	reg        rst_n;
	reg  [7:0] radio_event_mask;
	reg  [2:0] state;
	reg  [2:0] cal_target;
	reg [15:0] cal_cnt;
	reg  [7:0] data_buf;
	reg        rx_full;
	reg        tx_full;
	reg        tx_unf_ev;
	reg        rx_ovf_ev;
	reg        data_lvl_q;
	reg  [2:0] next_state;
	reg  [2:0] next_target;
	reg        next_cal;
	wire [7:0] radio_event_flags;
	wire [7:0] ev_cond;
	wire       strobe_wr;
	wire       flags_wr;
	wire       data_lvl;

	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	assign strobe_wr = sfr_wr_i && (sfr_addr_i == `RSIL_ADDR_STROBE);
	assign flags_wr  = sfr_wr_i && (sfr_addr_i == `RSIL_ADDR_EVENT_FLAGS);

	// Strobe decode; next_cal requests a calibration before next_target
	always @* begin
		next_state  = state;
		next_target = cal_target;
		next_cal    = 1'b0;
		if (strobe_wr) begin
			case (sfr_wdata_i)
			`RSIL_STB_SYNTH_ON: begin
				if (state == `RSIL_ST_IDLE && auto_calibration_setting_i) begin
					next_cal    = 1'b1; // [R1]
					next_target = `RSIL_ST_FS_ON;
				end else if (state == `RSIL_ST_IDLE ||
					(state == `RSIL_ST_RX && cca_enable_i)) begin
					next_state = `RSIL_ST_FS_ON; // [R1] [R2]
				end
			end
			`RSIL_STB_CALIBRATE: begin
				if (state == `RSIL_ST_IDLE) begin
					next_cal    = 1'b1; // [R3]
					next_target = `RSIL_ST_IDLE;
				end
			end
			`RSIL_STB_RECEIVE: begin
				if (state == `RSIL_ST_IDLE && auto_calibration_setting_i) begin
					next_cal    = 1'b1; // [R4]
					next_target = `RSIL_ST_RX;
				end else if (state == `RSIL_ST_IDLE || state == `RSIL_ST_FS_ON || state == `RSIL_ST_TX) begin
					next_state = `RSIL_ST_RX; // [R4]
				end
			end
			`RSIL_STB_TRANSMIT: begin
				if (state == `RSIL_ST_IDLE && auto_calibration_setting_i) begin
					next_cal    = 1'b1; // [R5]
					next_target = `RSIL_ST_TX;
				end else if (state == `RSIL_ST_IDLE || state == `RSIL_ST_FS_ON) begin
					next_state = `RSIL_ST_TX; // [R5]
				end else if (state == `RSIL_ST_RX && (!cca_enable_i || clear_channel_i)) begin
					next_state = `RSIL_ST_TX; // [R6]
				end
			end
			`RSIL_STB_IDLE: begin
				next_state = `RSIL_ST_IDLE; // [R7] [R21]
			end
			default: begin
				next_state = state; // [R8]
			end
			endcase
			if (next_cal)
				next_state = `RSIL_ST_CAL;
		end else begin
			case (state)
			`RSIL_ST_CAL: begin
				if (cal_cnt == 16'd0)
					next_state = cal_target;
			end
			`RSIL_ST_RX: begin
				if (rx_byte_i && rx_full && !data_rd_i)
					next_state = `RSIL_ST_RX_OVF; // [R20]
			end
			`RSIL_ST_TX: begin
				if (tx_byte_take_i && !tx_full)
					next_state = `RSIL_ST_TX_UNF; // [R21]
			end
			default: begin
				next_state = state;
			end
			endcase
		end
	end

	always @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			state      <= `RSIL_ST_IDLE;
			cal_target <= `RSIL_ST_IDLE;
			cal_cnt    <= 16'd0;
		end else begin
			state      <= next_state;
			cal_target <= next_target;
			if (next_state == `RSIL_ST_CAL && state != `RSIL_ST_CAL)
				cal_cnt <= CAL_CYCLES - 16'd1;
			else if (cal_cnt != 16'd0)
				cal_cnt <= cal_cnt - 16'd1;
		end
	end

	// One-byte data register shared by receive and transmit
	always @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			data_buf  <= 8'h00;
			rx_full   <= 1'b0;
			tx_full   <= 1'b0;
			rx_ovf_ev <= 1'b0;
			tx_unf_ev <= 1'b0;
		end else begin
			rx_ovf_ev <= (state == `RSIL_ST_RX) && rx_byte_i && rx_full && !data_rd_i; // [R20]
			tx_unf_ev <= (state == `RSIL_ST_TX) && tx_byte_take_i && !tx_full; // [R21]
			if (state == `RSIL_ST_RX) begin
				tx_full <= 1'b0;
				if (rx_byte_i && !(rx_full && !data_rd_i)) begin
					data_buf <= rx_data_i;
					rx_full  <= 1'b1;
				end else if (data_rd_i) begin
					rx_full <= 1'b0;
				end
			end else if (state == `RSIL_ST_TX) begin
				rx_full <= 1'b0;
				if (data_wr_i && !tx_full) begin
					data_buf <= data_wdata_i;
					tx_full  <= 1'b1;
				end else if (tx_byte_take_i) begin
					tx_full <= 1'b0;
				end
			end else if (state == `RSIL_ST_IDLE) begin
				// Stale bytes dropped on return to idle
				rx_full <= 1'b0;
				tx_full <= 1'b0;
			end
		end
	end

	assign data_lvl = ((state == `RSIL_ST_RX) && rx_full) ||
		((state == `RSIL_ST_TX) && !tx_full); // [R11]

	// Named event conditions, in the bit order of the flag register
	wire       cond_tx_underflow;
	wire       cond_rx_overflow;
	wire       cond_rx_timeout;
	wire       cond_packet_done;
	wire       cond_carrier_sense;
	wire       cond_preamble;
	wire       cond_clear_channel;
	wire       cond_sync_detected;

	assign cond_tx_underflow  = tx_unf_ev;
	assign cond_rx_overflow   = rx_ovf_ev;
	assign cond_rx_timeout    = rx_timeout_i;
	// Packet done also marks overflow and underflow
	assign cond_packet_done   = packet_done_i | tx_unf_ev | rx_ovf_ev; // [R17]
	assign cond_carrier_sense = carrier_sense_i;
	assign cond_preamble      = preamble_quality_i;
	assign cond_clear_channel = clear_channel_i;
	assign cond_sync_detected = sync_detected_i;

	assign ev_cond = {cond_tx_underflow, cond_rx_overflow, cond_rx_timeout, cond_packet_done,
		cond_carrier_sense, cond_preamble, cond_clear_channel, cond_sync_detected}; // [R16]

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_flag
			rsil_edge_flag u_flag ( // [R13]
				.clk_i   (clk_i),
				.rst_n_i (rst_n),
				.cond_i  (ev_cond[gi]),
				.wr_i    (flags_wr),
				.wr_bit_i(sfr_wdata_i[gi]),
				.flag_o  (radio_event_flags[gi])
			);
		end
	endgenerate

	// Mask register
	always @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			radio_event_mask <= `RSIL_MASK_RESET;
		end else begin
			if (sfr_wr_i && sfr_addr_i == `RSIL_ADDR_EVENT_MASK)
				radio_event_mask <= sfr_wdata_i; // [R18]
		end
	end

	// Data byte flag, set on the rising level of byte ready or room
	always @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			data_lvl_q           <= 1'b0;
			data_byte_cpu_flag_o <= 1'b0;
		end else begin
			data_lvl_q <= data_lvl;
			if (data_lvl && !data_lvl_q)
				data_byte_cpu_flag_o <= 1'b1; // [R11]
			else if (data_byte_flag_clr_i)
				data_byte_cpu_flag_o <= 1'b0;
		end
	end

	wire       masked_set;
	// Any masked flag still set wins over a same-cycle clear
	assign masked_set = |(radio_event_flags & radio_event_mask & ~{8{flags_wr}}) ||
		|(radio_event_flags & radio_event_mask & sfr_wdata_i);

	always @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			combined_radio_cpu_flag_o <= 1'b0;
		end else begin
			if (masked_set)
				combined_radio_cpu_flag_o <= 1'b1; // [R14]
			else if (radio_cpu_flag_clr_i)
				combined_radio_cpu_flag_o <= 1'b0;
		end
	end

	always @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			data_byte_irq_o <= 1'b0;
			radio_irq_o     <= 1'b0;
		end else begin
			data_byte_irq_o <= data_byte_cpu_flag_o & data_byte_irq_enable_i; // [R9] [R12]
			radio_irq_o     <= combined_radio_cpu_flag_o & radio_irq_enable_i; // [R9] [R15]
		end
	end

	// Read data holds until the next read
	always @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			sfr_rdata_o <= 8'h00;
		end else begin
			if (sfr_rd_i) begin
				case (sfr_addr_i)
				`RSIL_ADDR_EVENT_MASK:  sfr_rdata_o <= radio_event_mask;
				`RSIL_ADDR_EVENT_FLAGS: sfr_rdata_o <= radio_event_flags;
				default:                sfr_rdata_o <= 8'h00;
				endcase
			end
		end
	end

	// Status and data outputs, one cycle behind the internal state
	always @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			data_rdata_o    <= 8'h00;
			tx_byte_valid_o <= 1'b0;
			tx_byte_o       <= 8'h00;
			radio_state_o   <= `RSIL_ST_IDLE;
			synth_on_o      <= 1'b0;
		end else begin
			data_rdata_o    <= data_buf;
			tx_byte_valid_o <= (state == `RSIL_ST_TX) && tx_full;
			tx_byte_o       <= data_buf;
			radio_state_o   <= state;
			synth_on_o      <= (state != `RSIL_ST_IDLE) && !(state == `RSIL_ST_CAL && cal_target == `RSIL_ST_IDLE &&
				cal_cnt == 16'd0);
		end
	end
endmodule // rsil_top
`default_nettype wire

// *** sim/rsil_properties.sv ***
// Purpose: temporal checks on the strobe and interrupt ports
// Assumes: strobes spaced so the reported state settles in between
// Notes:   calibration length tracked by a counter, not a repetition
`default_nettype none
module rsil_properties #(
	parameter [15:0] CAL_CYCLES = 16'd64
) (
	input wire logic       clk_i,
	input wire logic       resetn_i,
	input wire logic       sfr_wr_i,
	input wire logic [7:0] sfr_addr_i,
	input wire logic [7:0] sfr_wdata_i,
	input wire logic       auto_calibration_setting_i,
	input wire logic       data_byte_irq_enable_i,
	input wire logic       radio_irq_enable_i,
	input wire logic       data_byte_cpu_flag_o,
	input wire logic       combined_radio_cpu_flag_o,
	input wire logic       data_byte_irq_o,
	input wire logic       radio_irq_o,
	input wire logic [2:0] radio_state_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] cal_cnt;
	wire         stb = sfr_wr_i && sfr_addr_i == 8'he1;
	wire         idle = radio_state_o == 3'd0;
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i)
			cal_cnt <= 16'h0000;
		else
			cal_cnt <= (radio_state_o == 3'd1) ? cal_cnt + 16'h0001 : 16'h0000;
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	chk_db_irq_gate: assert property (
		data_byte_irq_o == $past(data_byte_cpu_flag_o && data_byte_irq_enable_i)) else $error("data request wrong");
	chk_rf_irq_gate: assert property (
		radio_irq_o == $past(combined_radio_cpu_flag_o && radio_irq_enable_i)) else $error("radio request wrong");
	chk_idle_strobe: assert property (
		stb && sfr_wdata_i == 8'h04 |-> ##2 idle) else $error("idle strobe ignored");
	chk_cal_strobe: assert property (
		stb && sfr_wdata_i == 8'h01 && idle |-> ##2 radio_state_o == 3'd1) else $error("calibrate not started");
	chk_tx_autocal: assert property (
		stb && sfr_wdata_i == 8'h03 && idle && auto_calibration_setting_i |-> ##2 radio_state_o == 3'd1)
		else $error("transmit skipped calibration");
	chk_rx_direct: assert property (
		stb && sfr_wdata_i == 8'h02 && idle && !auto_calibration_setting_i |-> ##2 radio_state_o == 3'd3)
		else $error("receive not entered");
	chk_nop_code: assert property (
		stb && sfr_wdata_i > 8'h04 && idle |-> idle [*3]) else $error("unknown code acted");
	chk_cal_length: assert property (
		cal_cnt <= CAL_CYCLES + 16'd1) else $error("calibration too long");
	cover property (radio_state_o == 3'd5);
	cover property (radio_state_o == 3'd6);
	cover property (radio_irq_o);
endmodule // rsil_properties
bind rsil_top rsil_properties #(.CAL_CYCLES(CAL_CYCLES)) u_props (.*);
`default_nettype wire

// *** sim/rsil_cpu_model.sv ***
// Purpose: CPU side of the special function register port
// Assumes: one access at a time, driven on falling edges
// Notes:   released address and data are inverted so stale values never match
`default_nettype none
module rsil_cpu_model (
	input  wire logic       clk_i,
	input  wire logic [7:0] rdata_i,
	output var  logic       wr_o,
	output var  logic       rd_o,
	output var  logic [7:0] addr_o,
	output var  logic [7:0] wdata_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		{wr_o, rd_o, addr_o, wdata_o} = 18'h00000;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_i);
		{wr_o, addr_o, wdata_o} = {1'b1, a, d};
		@(negedge clk_i);
		{wr_o, addr_o, wdata_o} = {1'b0, ~a, ~d};
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk_i);
		{rd_o, addr_o} = {1'b1, a};
		@(negedge clk_i);
		{rd_o, addr_o} = {1'b0, ~a};
		@(negedge clk_i);
		d = rdata_i;
	endtask
endmodule // rsil_cpu_model
`default_nettype wire

// *** sim/radio_strobe_and_irq_logic_bench.sv ***
// Purpose: self-checking bench for strobe decode and event flags
// Assumes: short calibration parameter
// Notes:   random data from a fixed xorshift seed
`default_nettype none
module radio_strobe_and_irq_logic_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam [15:0] CAL = 16'd4;
	logic clk_i, resetn_i, sfr_wr_i, sfr_rd_i, data_wr_i, data_rd_i, rx_byte_i, tx_byte_take_i;
	logic auto_calibration_setting_i, cca_enable_i, data_byte_irq_enable_i, radio_irq_enable_i;
	logic data_byte_flag_clr_i, radio_cpu_flag_clr_i, tx_byte_valid_o, data_byte_cpu_flag_o;
	logic combined_radio_cpu_flag_o, data_byte_irq_o, radio_irq_o, synth_on_o;
	logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o, data_wdata_i, data_rdata_o, rx_data_i, tx_byte_o, v, r, c;
	logic [2:0] radio_state_o;
	logic [5:0] ev;
	logic [31:0] seed = 32'h18e41036;
	wire rx_timeout_i, packet_done_i, carrier_sense_i, preamble_quality_i, clear_channel_i, sync_detected_i;
	int mismatches, comparisons, k;
	assign {rx_timeout_i, packet_done_i, carrier_sense_i, preamble_quality_i, clear_channel_i, sync_detected_i} = ev;
	rsil_top #(.CAL_CYCLES(CAL)) u_dut (.*);
	rsil_cpu_model u_cpu (.clk_i(clk_i), .rdata_i(sfr_rdata_o), .wr_o(sfr_wr_i), .rd_o(sfr_rd_i),
		.addr_o(sfr_addr_i), .wdata_o(sfr_wdata_i));
	initial begin
		clk_i = 0;
		forever #2.5 clk_i = ~clk_i;
	end
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	function automatic logic [7:0] settled(logic [7:0] s);
		case (s)
			8'h00: return 8'h02;
			8'h02: return 8'h03;
			8'h03: return 8'h04;
			default: return 8'h00;
		endcase
	endfunction
	task automatic chk(string n, logic [7:0] seen, logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic cyc(int n);
		repeat (n) @(negedge clk_i);
	endtask
	task automatic stb(logic [7:0] s);
		u_cpu.wr(8'he1, s);
		cyc(3);
	endtask
	task automatic flags(logic [7:0] exp);
		u_cpu.rd(8'he9, r);
		chk("flags", r, exp);
	endtask
	initial begin
		{data_wr_i, data_rd_i, rx_byte_i, tx_byte_take_i, auto_calibration_setting_i, cca_enable_i} = 6'h00;
		{data_byte_irq_enable_i, radio_irq_enable_i, data_byte_flag_clr_i, radio_cpu_flag_clr_i} = 4'h0;
		{ev, data_wdata_i, rx_data_i, resetn_i} = 23'h000000;
		cyc(3);
		resetn_i = 1;
		cyc(4);
		u_cpu.rd(8'h91, r);
		chk("mask", r, 8'h00);
		flags(8'h00);
		v = rnd();
		u_cpu.wr(8'h91, v);
		u_cpu.rd(8'h91, r);
		chk("mask", r, v);
		for (k = 0; k < 6; k++) begin
			ev[k] = 1;
			cyc(3);
			flags(8'h01 << k);
			u_cpu.wr(8'he9, 8'hff);
			flags(8'h01 << k);
			u_cpu.wr(8'he9, 8'h00);
			flags(8'h00);
			ev[k] = 0;
		end
		// Masked event must not reach the CPU flag
		{radio_irq_enable_i, radio_cpu_flag_clr_i} = 2'b11;
		u_cpu.wr(8'h91, 8'h02);
		radio_cpu_flag_clr_i = 0;
		ev[0] = 1;
		cyc(4);
		chk("combined", combined_radio_cpu_flag_o, 1'b0);
		u_cpu.wr(8'h91, 8'h01);
		ev[0] = 0;
		cyc(2);
		ev[0] = 1;
		cyc(4);
		chk("combined", combined_radio_cpu_flag_o, 1'b1);
		chk("radio_irq", radio_irq_o, 1'b1);
		{ev, radio_cpu_flag_clr_i} = 7'h01;
		u_cpu.wr(8'he9, 8'h00);
		radio_cpu_flag_clr_i = 0;
		for (k = 0; k < 12; k++) begin
			c = (k % 6 == 5) ? 8'h05 + rnd() % 8'hfa : 8'(k % 6);
			auto_calibration_setting_i = k < 6;
			stb(c);
			cyc(CAL + 4);
			chk("state", {5'h00, radio_state_o}, settled(c));
			if (c == 8'h00)
				chk("synth", synth_on_o, 1'b1);
			stb(8'h04);
			chk("state", {5'h00, radio_state_o}, 8'h00);
			chk("synth", synth_on_o, 1'b0);
		end
		{auto_calibration_setting_i, data_byte_irq_enable_i} = 2'b01;
		// Flag left set by the transmit passes above; start receive from a clear flag
		data_byte_flag_clr_i = 1;
		cyc(1);
		data_byte_flag_clr_i = 0;
		cyc(1);
		chk("data_flag", data_byte_cpu_flag_o, 1'b0);
		stb(8'h02);
		rx_data_i = rnd();
		rx_byte_i = 1;
		cyc(1);
		rx_byte_i = 0;
		cyc(3);
		chk("data_flag", data_byte_cpu_flag_o, 1'b1);
		chk("data_irq", data_byte_irq_o, 1'b1);
		chk("data", data_rdata_o, rx_data_i);
		rx_byte_i = 1;
		cyc(1);
		rx_byte_i = 0;
		cyc(3);
		chk("state", {5'h00, radio_state_o}, 8'h05);
		flags(8'h50);
		stb(8'h04);
		chk("state", {5'h00, radio_state_o}, 8'h00);
		u_cpu.wr(8'he9, 8'h00);
		stb(8'h03);
		tx_byte_take_i = 1;
		cyc(1);
		tx_byte_take_i = 0;
		cyc(3);
		chk("state", {5'h00, radio_state_o}, 8'h06);
		flags(8'h90);
		stb(8'h04);
		cca_enable_i = 1;
		stb(8'h02);
		stb(8'h03);
		chk("state", {5'h00, radio_state_o}, 8'h03);
		ev[1] = 1;
		stb(8'h03);
		chk("state", {5'h00, radio_state_o}, 8'h04);
		stb(8'h04);
		stb(8'h02);
		stb(8'h00);
		chk("state", {5'h00, radio_state_o}, 8'h02);
		wrap_up();
	end
	initial begin
		repeat (4000) @(posedge clk_i);
		mismatches++;
		wrap_up();
	end
endmodule // radio_strobe_and_irq_logic_bench
`default_nettype wire
